// ===== src/smsp_pkg.sv
// What this block does
// - One byte each way, MSB first
// - Master-in line: input as master, output slave
// - Master-out line: output as master, input slave
// - One bit per clock period, eight periods
// - Clock pin output as master, input slave
// - Launch on one edge, sample the other
// - Slave moves data only while select low
// - Slave read of bit 0 gives select
// - Done flag bit 7 set per byte
// - Done clears by zero write or data read
// - Data write while busy sets collision bit
// - Enable bit 5 hands pins to interface
// - Bit 4 picks master or slave
// - Bit 3 sets clock idle level
// - Bit 2 picks launching clock edge
// - Master rate: oscillator over 4/8/32/64
// - Data write transmits, read returns received
// - Select is digital only with port bit clear
// - Master data write starts eight clocks
// - Slave data write loads byte to send
// - Received byte latched only at byte end
package smsp_pkg;
  localparam logic [7:0] SMSP_ADDR_DATA = 8'hF7;
  localparam logic [7:0] SMSP_ADDR_CTRL = 8'hF8;
  localparam logic [7:0] SMSP_DATA_RESET = 8'h00;
  localparam logic [7:0] SMSP_CTRL_RESET = 8'h00;
  localparam int SMSP_POS_DONE = 7;
  localparam int SMSP_POS_WRITE_COLLISION_FLAG = 6;
  localparam int SMSP_POS_RATE_LOW = 0;
  localparam int SMSP_BITS = 8;
  localparam logic [3:0] SMSP_BITS_CNT = 4'h8;
  localparam logic [3:0] SMSP_LAST_BIT = 4'h7;
  localparam logic [4:0] SMSP_LAST_EDGE = 5'h0F;
  localparam int SMSP_BUF_DEPTH = 2;
  localparam int SMSP_CLK_NS = 40;
  localparam int SMSP_DIV0 = 4;
  localparam int SMSP_DIV1 = 8;
  localparam int SMSP_DIV2 = 32;
  localparam int SMSP_DIV3 = 64;

  typedef struct packed {
    logic done;
    logic write_collision_flag;
    logic en;
    logic master;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic rate_high;
    logic rate_low;
  } smsp_ctrl_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } smsp_pins_t;
endpackage

// ===== src/smsp_buf.sv
`timescale 1ns/1ps
module smsp_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST) ? '0 : p + PW'(1);
  endfunction

  assign o_in_ready = (count != FULL);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop)
      begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push & ~pop)
      begin
        count <= count + CW'(1);
      end
      else if (pop & ~push)
      begin
        count <= count - CW'(1);
      end
    end
  end
endmodule

// ===== src/smsp_core.sv
`timescale 1ns/1ps
module smsp_core #(
  parameter int BUF_DEPTH = smsp_pkg::SMSP_BUF_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_sclk_in,
  input wire logic i_mosi_in,
  input wire logic i_miso_in,
  input wire logic i_ss_n,
  input wire logic i_select_port_bit,
  output smsp_pkg::smsp_pins_t o_pins,
  output logic o_pins_owned
);
  typedef enum logic {SMSP_IDLE, SMSP_RUN} smsp_state_t;

  smsp_pkg::smsp_ctrl_t ctrl;
  smsp_state_t state;
  logic [7:0] data_reg;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [3:0] bit_cnt;
  logic [4:0] edge_cnt;
  logic [5:0] div_cnt;
  logic sclk_q;
  logic [3:0] in_meta;
  logic [3:0] in_sync;
  logic sclk_prev;
  logic ss_prev;
  logic rx_valid;
  logic [7:0] rx_word;
  logic rx_ready;
  logic drain_valid;
  logic drain_ready;
  logic [7:0] drain_data;
  logic drain_fire;

  logic wr_data, rd_data, wr_ctrl, rd_ctrl;
  logic en, master, ss_eff, slave_sel, busy, start, collision;
  logic s_edge, s_leading, m_edge, edge_now, leading, sample, launch;
  logic serial_in, m_end, s_end_ph1, s_end_ph0, byte_end;
  logic m_late, m_end_d;
  logic [7:0] end_word;

  function automatic logic [5:0] half_period(input logic [1:0] rate);
    case (rate)
      2'h0: half_period = 6'(smsp_pkg::SMSP_DIV0 / 2);
      2'h1: half_period = 6'(smsp_pkg::SMSP_DIV1 / 2);
      2'h2: half_period = 6'(smsp_pkg::SMSP_DIV2 / 2);
      default: half_period = 6'(smsp_pkg::SMSP_DIV3 / 2);
    endcase
  endfunction

  assign wr_data = i_sfr_wr & (i_sfr_addr == smsp_pkg::SMSP_ADDR_DATA);
  assign rd_data = i_sfr_rd & (i_sfr_addr == smsp_pkg::SMSP_ADDR_DATA);
  assign wr_ctrl = i_sfr_wr & (i_sfr_addr == smsp_pkg::SMSP_ADDR_CTRL);
  assign rd_ctrl = i_sfr_rd & (i_sfr_addr == smsp_pkg::SMSP_ADDR_CTRL);

  // Pins arrive from outside: two flops before use
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      in_meta <= 4'hF;
      in_sync <= 4'hF;
      sclk_prev <= 1'b1;
      ss_prev <= 1'b1;
    end
    else
    begin
      in_meta <= {i_ss_n, i_miso_in, i_mosi_in, i_sclk_in};
      in_sync <= in_meta;
      sclk_prev <= in_sync[0];
      ss_prev <= ss_eff;
    end
  end

  assign en = ctrl.en;
  assign master = en & ctrl.master;
  assign ss_eff = in_sync[3] | i_select_port_bit;
  assign slave_sel = en & ~ctrl.master & ~ss_eff;
  assign o_pins_owned = en;

  // Polarity and phase must match the far end
  assign s_edge = slave_sel & (in_sync[0] ^ sclk_prev);
  assign s_leading = ctrl.clock_polarity_bit ? ~in_sync[0] : in_sync[0];
  assign m_edge = (state == SMSP_RUN) & (div_cnt == 6'h00);
  assign edge_now = master ? m_edge : s_edge;
  assign leading = master ? ~edge_cnt[0] : s_leading;
  // Master samples a cycle late so the synchroniser delay fits even at the fastest rate
  assign sample = master ? m_late : edge_now & (leading ^ ctrl.clock_phase_bit);
  assign launch = edge_now & ~(leading ^ ctrl.clock_phase_bit);
  assign serial_in = master ? in_sync[2] : in_sync[1];

  assign busy = (state == SMSP_RUN) | (slave_sel & (bit_cnt != 4'h0));
  assign start = wr_data & ~busy & master;
  assign collision = wr_data & busy;

  assign end_word = sample ? {rx_sh[6:0], serial_in} : rx_sh;
  assign m_end = m_edge & (edge_cnt == smsp_pkg::SMSP_LAST_EDGE);
  assign s_end_ph1 = slave_sel & ctrl.clock_phase_bit & sample
                     & (bit_cnt == smsp_pkg::SMSP_LAST_BIT);
  // Phase zero ends only when the master lifts select
  assign s_end_ph0 = en & ~ctrl.master & ~ctrl.clock_phase_bit & ss_eff & ~ss_prev
                     & (bit_cnt == smsp_pkg::SMSP_BITS_CNT);
  assign byte_end = m_end_d | s_end_ph1 | s_end_ph0;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      m_late <= 1'b0;
      m_end_d <= 1'b0;
    end
    else
    begin
      m_late <= master & m_edge & (leading ^ ctrl.clock_phase_bit);
      m_end_d <= m_end;
    end
  end

  // Master clock generator and burst sequencing
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= SMSP_IDLE;
      div_cnt <= 6'h00;
      edge_cnt <= 5'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      case (state)
        SMSP_IDLE:
        begin
          sclk_q <= ctrl.clock_polarity_bit;
          if (start)
          begin
            state <= SMSP_RUN;
            div_cnt <= half_period({ctrl.rate_high, ctrl.rate_low}) - 6'h01;
            edge_cnt <= 5'h00;
          end
        end
        SMSP_RUN:
        begin
          if (!master)
          begin
            state <= SMSP_IDLE;
          end
          else if (m_edge)
          begin
            sclk_q <= ~sclk_q;
            edge_cnt <= edge_cnt + 5'h01;
            div_cnt <= half_period({ctrl.rate_high, ctrl.rate_low}) - 6'h01;
            if (m_end)
            begin
              state <= SMSP_IDLE;
            end
          end
          else
          begin
            div_cnt <= div_cnt - 6'h01;
          end
        end
        default: state <= SMSP_IDLE;
      endcase
    end
  end

  // Shift engine shared by both modes
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      bit_cnt <= 4'h0;
    end
    else
    begin
      if (wr_data & ~busy)
      begin
        tx_sh <= i_sfr_wdata;
      end
      else if (launch & (bit_cnt != 4'h0))
      begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
      if (start | byte_end | (~master & ~slave_sel))
      begin
        bit_cnt <= 4'h0;
      end
      else if (sample)
      begin
        rx_sh <= {rx_sh[6:0], serial_in};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // Finished byte waits here until the buffer takes it
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_valid <= 1'b0;
      rx_word <= 8'h00;
    end
    else if (byte_end)
    begin
      rx_valid <= 1'b1;
      rx_word <= end_word;
    end
    else if (rx_ready)
    begin
      rx_valid <= 1'b0;
    end
  end

  smsp_buf #(
    .WIDTH(smsp_pkg::SMSP_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(rx_valid),
    .o_in_ready(rx_ready),
    .i_in_data(rx_word),
    .o_out_valid(drain_valid),
    .i_out_ready(drain_ready),
    .o_out_data(drain_data)
  );

  // Hold a new byte while software reads the old one
  assign drain_ready = ~rd_data;
  assign drain_fire = drain_valid & drain_ready;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      data_reg <= smsp_pkg::SMSP_DATA_RESET;
    end
    else if (drain_fire)
    begin
      data_reg <= drain_data;
    end
  end

  // Flags: hardware set wins over any clear
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl <= smsp_pkg::SMSP_CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl.en <= i_sfr_wdata[5];
        ctrl.master <= i_sfr_wdata[4];
        ctrl.clock_polarity_bit <= i_sfr_wdata[3];
        ctrl.clock_phase_bit <= i_sfr_wdata[2];
        ctrl.rate_high <= i_sfr_wdata[1];
        ctrl.rate_low <= i_sfr_wdata[0];
      end
      ctrl.done <= drain_fire | (ctrl.done & ~rd_data
                   & ~(wr_ctrl & ~i_sfr_wdata[smsp_pkg::SMSP_POS_DONE]));
      ctrl.write_collision_flag <= collision | (ctrl.write_collision_flag
                   & ~(wr_ctrl & ~i_sfr_wdata[smsp_pkg::SMSP_POS_WRITE_COLLISION_FLAG]));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_sfr_rdata <= 8'h00;
    end
    else if (rd_ctrl)
    begin
      o_sfr_rdata <= ctrl;
      if (!ctrl.master)
      begin
        o_sfr_rdata[smsp_pkg::SMSP_POS_RATE_LOW] <= ss_eff;
      end
    end
    else if (rd_data)
    begin
      o_sfr_rdata <= data_reg;
    end
  end

  always_comb
  begin
    o_pins.sclk_o = (state == SMSP_RUN) ? sclk_q : ctrl.clock_polarity_bit;
    o_pins.sclk_oe = master;
    o_pins.mosi_o = tx_sh[7];
    o_pins.mosi_oe = master;
    o_pins.miso_o = tx_sh[7];
    o_pins.miso_oe = slave_sel;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sclk_idle_level_a: assert property (disable iff (!i_rst_n || wr_ctrl)
    m_end |=> sclk_q == ctrl.clock_polarity_bit && o_pins.sclk_o == ctrl.clock_polarity_bit)
    else $error("idle clock level wrong");
  mosi_dir_a: assert property (o_pins.mosi_oe == (en && ctrl.master)) else $error("master-out direction wrong");
  miso_dir_a: assert property (o_pins.miso_oe |-> en && !ctrl.master && !ss_eff) else $error("master-in driven wrongly");
  sclk_dir_a: assert property (o_pins.sclk_oe == (ctrl.en && ctrl.master)) else $error("clock direction wrong");
  pins_released_a: assert property (!en |-> !o_pins.sclk_oe && !o_pins.mosi_oe && !o_pins.miso_oe) else $error("pins driven while disabled");
  burst_length_a: assert property (disable iff (!i_rst_n || wr_ctrl) start && !ctrl.rate_high && !ctrl.rate_low |=> (state == SMSP_RUN) ##31 (state == SMSP_RUN) ##1 (state == SMSP_IDLE)) else $error("burst length wrong");
  write_collision_flag_set_a: assert property (collision |=> ctrl.write_collision_flag) else $error("collision not flagged");
  done_set_a: assert property (drain_fire |=> ctrl.done && data_reg == $past(drain_data)) else $error("byte end not flagged");
  done_clear_a: assert property (rd_data && !drain_fire |=> !ctrl.done) else $error("data read kept done flag");
  msb_first_a: assert property (start |=> o_pins.mosi_o == $past(i_sfr_wdata[7])) else $error("first bit not MSB");
  select_read_a: assert property (rd_ctrl && !ctrl.master |=> o_sfr_rdata[0] == $past(ss_eff)) else $error("select readback wrong");
  edge_count_a: assert property (m_end_d |-> bit_cnt == smsp_pkg::SMSP_BITS_CNT
    || (ctrl.clock_phase_bit && sample)) else $error("bit count wrong at end");

  master_burst_c: cover property (start ##[1:600] m_end);
  slave_ph1_c: cover property (s_end_ph1);
  slave_ph0_c: cover property (s_end_ph0);
  collision_c: cover property (collision);
endmodule

// ===== verification/smsp_peer.sv
`timescale 1ns/1ps
module smsp_peer (
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_sel,
  input wire logic i_clock_polarity_bit,
  input wire logic i_clock_phase_bit,
  input wire logic [7:0] i_tx,
  output logic [7:0] o_rx,
  output logic o_miso
);
  logic [7:0] sh;
  logic [3:0] n;
  // Released line flips so a stale bit never looks valid
  assign o_miso = i_sel ? sh[7] : ~sh[7];
  always @(posedge i_sel)
  begin
    sh = i_tx;
    n = 4'h0;
  end
  // Same mode as the device; launch and sample on opposite edges
  always @(i_sclk)
  begin
    if (i_sel && ((i_sclk ^ i_clock_polarity_bit) == 1'b1))
    begin
      if (!i_clock_phase_bit)
        o_rx = {o_rx[6:0], i_mosi};
      else if (n != 4'h0)
        sh = sh << 1;
      n = n + 4'h1;
    end
    else if (i_sel)
    begin
      if (i_clock_phase_bit)
        o_rx = {o_rx[6:0], i_mosi};
      else
        sh = sh << 1;
    end
  end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] o_sfr_rdata;
  logic m_sclk = 1'b0;
  logic m_mosi = 1'b0;
  logic i_ss_n = 1'b0;
  logic i_select_port_bit = 1'b0;
  smsp_pkg::smsp_pins_t o_pins;
  logic o_pins_owned;
  logic sclk, mosi, miso, p_miso, psclk;
  logic p_sel = 1'b0;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] cfg = 8'h00;
  logic [7:0] p_rx, rv, tx, got;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int ne = 0;
  int first, last, half;
  always #20 i_clk = ~i_clk;
  // Wire level from whoever enables its driver
  assign sclk = o_pins.sclk_oe ? o_pins.sclk_o : m_sclk;
  assign mosi = o_pins.mosi_oe ? o_pins.mosi_o : m_mosi;
  assign miso = o_pins.miso_oe ? o_pins.miso_o : p_miso;
  smsp_core u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_sclk_in(sclk), .i_mosi_in(mosi), .i_miso_in(miso),
    .i_ss_n(i_ss_n), .i_select_port_bit(i_select_port_bit), .o_pins(o_pins),
    .o_pins_owned(o_pins_owned));
  smsp_peer u_peer (.i_sclk(sclk), .i_mosi(mosi), .i_sel(p_sel), .i_clock_polarity_bit(cfg[3]),
    .i_clock_phase_bit(cfg[2]), .i_tx(p_tx), .o_rx(p_rx), .o_miso(p_miso));
  task automatic close_out();
    $display("Counts: %0d compared, %0d failures", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Edge counter and hang guard
  always @(posedge i_clk)
  begin
    cyc++;
    if (sclk !== psclk)
    begin
      if (ne == 0)
        first = cyc;
      last = cyc;
      ne++;
    end
    psclk = sclk;
    if (cyc == 20000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tk(1);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    tk(1);
    i_sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tk(1);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    tk(1);
    i_sfr_rd = 1'b0;
    d = o_sfr_rdata;
  endtask
  task automatic wait_done();
    for (int k = 0; k < 400; k++)
    begin
      rd(8'hF8, rv);
      if (rv[7] === 1'b1)
        break;
    end
  endtask
  function automatic int div(input logic [1:0] r);
    return (r == 2'h0) ? 4 : (r == 2'h1) ? 8 : (r == 2'h2) ? 32 : 64;
  endfunction
  initial
  begin
    void'($urandom(10));
    tk(16);
    i_rst_n = 1'b1;
    tk(2);
    rd(8'hF8, rv);
    chk(rv, 8'h00);
    rd(8'hF7, rv);
    chk(rv, 8'h00);
    chk({o_pins_owned, o_pins}, 7'h00);
    $display("Reset test done");
    // Every mode and every rate once
    for (int i = 0; i < 4; i++)
    begin
      cfg = {4'h3, i[0], i[1], i[1:0]};
      half = div(i[1:0]) / 2;
      tx = 8'($urandom);
      p_tx = 8'($urandom);
      wr(8'hF8, cfg);
      chk({o_pins_owned, o_pins.sclk_oe, o_pins.mosi_oe, o_pins.miso_oe}, 4'hE);
      chk(sclk, cfg[3]);
      p_sel = 1'b1;
      tk(1);
      ne = 0;
      wr(8'hF7, tx);
      wr(8'hF7, ~tx);
      wait_done();
      p_sel = 1'b0;
      chk(rv, cfg | 8'hC0);
      chk(16'(ne), 16'd16);
      chk(16'(last - first), 16'(15 * half));
      chk(p_rx, tx);
      rd(8'hF7, rv);
      chk(rv, p_tx);
      rd(8'hF8, rv);
      chk(rv, cfg | 8'h40);
      wr(8'hF8, cfg);
      rd(8'hF8, rv);
      chk(rv, cfg);
      rd(8'h00, rv);
      chk(rv, cfg);
      $display("Master test %0d done", i);
    end
    for (int i = 0; i < 2; i++)
    begin
      cfg = {4'h2, 1'($urandom), i[0], 2'h0};
      tx = 8'($urandom);
      p_tx = 8'($urandom);
      i_ss_n = 1'b1;
      m_sclk = cfg[3];
      wr(8'hF8, cfg);
      wr(8'hF7, tx);
      tk(3);
      rd(8'hF8, rv);
      chk(rv, cfg | 8'h01);
      chk(o_pins.miso_oe, 1'b0);
      i_ss_n = 1'b0;
      tk(5);
      chk(o_pins.miso_oe, 1'b1);
      for (int b = 7; b >= 0; b--)
      begin
        if (!cfg[2])
          m_mosi = p_tx[b];
        tk(5);
        if (!cfg[2])
          got[b] = miso;
        m_sclk = ~cfg[3];
        if (cfg[2])
          m_mosi = p_tx[b];
        tk(5);
        if (cfg[2])
          got[b] = miso;
        m_sclk = cfg[3];
      end
      tk(5);
      if (!cfg[2])
      begin
        rd(8'hF8, rv);
        chk(rv, cfg);
      end
      else
      begin
        // Select still low: phase one ends on the eighth clock
        wait_done();
        chk(rv, cfg | 8'h80);
      end
      i_ss_n = 1'b1;
      tk(2);
      wait_done();
      chk(rv, cfg | 8'h81);
      chk(got, tx);
      rd(8'hF7, rv);
      chk(rv, p_tx);
      $display("Slave test %0d done", i);
    end
    i_ss_n = 1'b0;
    i_select_port_bit = 1'b1;
    tk(4);
    rd(8'hF8, rv);
    chk(rv[0], 1'b1);
    i_select_port_bit = 1'b0;
    $display("Select port test done");
    wr(8'hF8, 8'h10);
    wr(8'hF7, 8'($urandom));
    tk(40);
    chk({o_pins_owned, o_pins.sclk_oe, o_pins.mosi_oe, o_pins.miso_oe}, 4'h0);
    rd(8'hF8, rv);
    chk(rv, 8'h10);
    // Disabled slave with select low must ignore a full byte of clocks
    wr(8'hF8, 8'h04);
    repeat (16)
    begin
      m_sclk = ~m_sclk;
      tk(4);
    end
    rd(8'hF8, rv);
    chk(rv, 8'h04);
    $display("Disabled test done");
    close_out();
  end
endmodule
